// *** verilog/mhp_pkg.sv ***
package mhp_pkg;

   // ***************************************************************
   // register locations
   // ***************************************************************
   localparam logic [7:0] REG_IRQ_REQUEST = 8'h01; // irq_request_reg, read only
   localparam logic [7:0] REG_IRQ_MASK = 8'h02; // irq_mask_reg
   localparam logic [7:0] REG_IRQ_CLEAR = 8'h03; // irq_clear_reg, zeros clear
   localparam logic [7:0] REG_ERR_ENABLE = 8'h04; // error enables
   localparam logic [7:0] REG_TX_AUX = 8'h05; // tx aux channel enables
   localparam logic [7:0] REG_COMMAND = 8'hF3; // command register

   // ***************************************************************
   // field positions and forced values
   // ***************************************************************
   localparam int BIT_TX_ERR_EN = 0;
   localparam int BIT_CLK_REC_ERR_EN = 1;
   localparam int BIT_RX_ERR_EN = 2;
   localparam int BIT_RX_AUX_EN = 6;
   localparam logic [7:0] MASK_FORCED = 8'hFF; // mask value under device reset
   localparam logic [7:0] ERR_EN_FORCED_CLR = 8'h07; // error enable bits
   localparam logic [7:0] TX_AUX_FORCED_CLR = 8'h07; // three tx aux enables
   localparam logic [7:0] CMD_FORCED_CLR = 8'hC0; // added command bits incl rx aux
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [7:0] MASK_RESET = 8'hFF; // mask after power-up reset
   localparam int REG_COUNT = 256;

   // bus style values
   localparam logic STYLE_SEPARATE = 1'b0;
   localparam logic STYLE_DIRECTION = 1'b1;

   // ***************************************************************
   // carriers
   // ***************************************************************
   typedef struct packed {
      logic cs_n;
      logic ale;
      logic rd_n;
      logic wr_n;
      logic style;
      logic dev_reset_n;
      logic [7:0] ad;
   } mhp_pins_t;

   typedef struct packed {
      logic [2:0] tx_aux;
      logic rx_aux;
      logic tx_err_en;
      logic clk_rec_err_en;
      logic rx_err_en;
      logic [7:0] command;
   } mhp_cfg_t;

endpackage : mhp_pkg

// *** verilog/mhp_port.sv ***
`timescale 1ns/1ns
module mhp_port (
   input wire logic clk_sys, // 100 MHz system clock
   input wire logic reset_n, // async power-up reset
   input wire logic cs_n, // chip select pin
   input wire logic ale, // address latch strobe pin
   input wire logic rd_n, // read or data strobe pin
   input wire logic wr_n, // write strobe or direction pin
   input wire logic bus_style_select, // static bus style pin
   input wire logic dev_reset_n, // device reset pin
   input wire logic [7:0] ad_in, // shared bus, input side
   output logic [7:0] ad_out, // shared bus, output side
   output logic ad_oe, // shared bus drive enable
   input wire logic [7:0] irq_event, // request set pulses, clk_sys domain
   output logic irq_out_n, // open-drain level, always low
   output logic irq_out_n_oe, // open-drain pull enable
   output mhp_pkg::mhp_cfg_t cfg // configuration bits to the core
);

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   mhp_pkg::mhp_pins_t pins_in;
   mhp_pkg::mhp_pins_t meta_q, meta_d;
   mhp_pkg::mhp_pins_t sync_q, sync_d;
   mhp_pkg::mhp_pins_t prev_q, prev_d;

   // gather pins into one carrier
   always_comb
   begin
      pins_in.cs_n = cs_n;
      pins_in.ale = ale;
      pins_in.rd_n = rd_n;
      pins_in.wr_n = wr_n;
      pins_in.style = bus_style_select;
      pins_in.dev_reset_n = dev_reset_n;
      pins_in.ad = ad_in;
   end

   // two stages, then one more for edge detection
   always_comb
   begin
      meta_d = pins_in;
      sync_d = meta_q;
      prev_d = sync_q;
   end

   // idle pin levels on reset so no false edge appears
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_q <= '{cs_n: 1'b1, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, style: 1'b0,
                     dev_reset_n: 1'b1, ad: mhp_pkg::BYTE_ZERO};
         sync_q <= '{cs_n: 1'b1, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, style: 1'b0,
                     dev_reset_n: 1'b1, ad: mhp_pkg::BYTE_ZERO};
         prev_q <= '{cs_n: 1'b1, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, style: 1'b0,
                     dev_reset_n: 1'b1, ad: mhp_pkg::BYTE_ZERO};
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   // ***************************************************************
   // cycle decode
   // ***************************************************************
   logic rd_now, wr_now, wr_before, ale_fall, wr_commit;

   // strobe meaning depends on the style pin
   always_comb
   begin
      if (sync_q.style == mhp_pkg::STYLE_SEPARATE)
      begin
         rd_now = !sync_q.cs_n && !sync_q.rd_n;
         wr_now = !sync_q.cs_n && !sync_q.wr_n;
      end
      else
      begin
         rd_now = !sync_q.cs_n && !sync_q.rd_n && sync_q.wr_n;
         wr_now = !sync_q.cs_n && !sync_q.rd_n && !sync_q.wr_n;
      end
      if (prev_q.style == mhp_pkg::STYLE_SEPARATE)
         wr_before = !prev_q.cs_n && !prev_q.wr_n;
      else
         wr_before = !prev_q.cs_n && !prev_q.rd_n && !prev_q.wr_n;
      ale_fall = prev_q.ale && !sync_q.ale;
      // write lands as the strobe or chip select ends, data from the last cycle
      wr_commit = wr_before && !wr_now;
   end

   // ***************************************************************
   // address latch
   // ***************************************************************
   logic [7:0] addr_q, addr_d;

   // bus value from the cycle while the strobe was still high
   always_comb
   begin
      addr_d = addr_q;
      if (ale_fall)
         addr_d = prev_q.ad;
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         addr_q <= mhp_pkg::BYTE_ZERO;
      else
         addr_q <= addr_d;
   end

   // ***************************************************************
   // register locations
   // ***************************************************************
   logic [7:0] mem_q [mhp_pkg::REG_COUNT];
   logic [7:0] mem_d [mhp_pkg::REG_COUNT];
   logic [7:0] irq_req_q, irq_req_d;
   logic dev_reset_act;

   assign dev_reset_act = !sync_q.dev_reset_n;

   // write path, then the forced bits of device reset on top;
   // other bits keep their value, and writes still land during reset
   always_comb
   begin
      for (int i = 0; i < mhp_pkg::REG_COUNT; i++)
         mem_d[i] = mem_q[i];
      if (wr_commit && addr_q != mhp_pkg::REG_IRQ_REQUEST)
         mem_d[addr_q] = prev_q.ad;
      if (dev_reset_act)
      begin
         mem_d[mhp_pkg::REG_IRQ_MASK] = mhp_pkg::MASK_FORCED;
         mem_d[mhp_pkg::REG_ERR_ENABLE] =
            mem_d[mhp_pkg::REG_ERR_ENABLE] & ~mhp_pkg::ERR_EN_FORCED_CLR;
         mem_d[mhp_pkg::REG_TX_AUX] =
            mem_d[mhp_pkg::REG_TX_AUX] & ~mhp_pkg::TX_AUX_FORCED_CLR;
         mem_d[mhp_pkg::REG_COMMAND] =
            mem_d[mhp_pkg::REG_COMMAND] & ~mhp_pkg::CMD_FORCED_CLR;
      end
   end

   // masks start set so nothing interrupts before software is ready
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < mhp_pkg::REG_COUNT; i++)
            mem_q[i] <= (i == int'(mhp_pkg::REG_IRQ_MASK)) ? mhp_pkg::MASK_RESET
                                                           : mhp_pkg::BYTE_ZERO;
      end
      else
      begin
         for (int i = 0; i < mhp_pkg::REG_COUNT; i++)
            mem_q[i] <= mem_d[i];
      end
   end

   // ***************************************************************
   // interrupt requests
   // ***************************************************************
   // a zero written to the clear location drops that request;
   // a new event in the same cycle wins over the clear
   always_comb
   begin
      irq_req_d = irq_req_q;
      if (wr_commit && addr_q == mhp_pkg::REG_IRQ_CLEAR)
         irq_req_d = irq_req_d & prev_q.ad;
      irq_req_d = irq_req_d | irq_event;
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         irq_req_q <= mhp_pkg::BYTE_ZERO;
      else
         irq_req_q <= irq_req_d;
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   logic [7:0] ad_out_q, ad_out_d;
   logic ad_oe_q, ad_oe_d;
   logic irq_oe_q, irq_oe_d;
   mhp_pkg::mhp_cfg_t cfg_q, cfg_d;

   // bus drive only in a read data phase; three cycles late on release (two pin stages plus the output flop),
   // so the host must allow a short float time after the strobe ends
   always_comb
   begin
      ad_oe_d = rd_now;
      if (addr_q == mhp_pkg::REG_IRQ_REQUEST)
         ad_out_d = irq_req_q;
      else
         ad_out_d = mem_q[addr_q];
      irq_oe_d = |(irq_req_d & ~mem_d[mhp_pkg::REG_IRQ_MASK]);
      cfg_d.tx_aux = mem_d[mhp_pkg::REG_TX_AUX][2:0];
      cfg_d.rx_aux = mem_d[mhp_pkg::REG_COMMAND][mhp_pkg::BIT_RX_AUX_EN];
      cfg_d.tx_err_en = mem_d[mhp_pkg::REG_ERR_ENABLE][mhp_pkg::BIT_TX_ERR_EN];
      cfg_d.clk_rec_err_en = mem_d[mhp_pkg::REG_ERR_ENABLE][mhp_pkg::BIT_CLK_REC_ERR_EN];
      cfg_d.rx_err_en = mem_d[mhp_pkg::REG_ERR_ENABLE][mhp_pkg::BIT_RX_ERR_EN];
      cfg_d.command = mem_d[mhp_pkg::REG_COMMAND];
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ad_out_q <= mhp_pkg::BYTE_ZERO;
         ad_oe_q <= 1'b0;
         irq_oe_q <= 1'b0;
         cfg_q <= '0;
      end
      else
      begin
         ad_out_q <= ad_out_d;
         ad_oe_q <= ad_oe_d;
         irq_oe_q <= irq_oe_d;
         cfg_q <= cfg_d;
      end
   end

   // open drain: level is a constant low flop, pull follows the enable
   logic irq_lvl_q, irq_lvl_d;

   // the level never moves; only the enable pulls the line
   always_comb
   begin
      irq_lvl_d = 1'b0;
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         irq_lvl_q <= 1'b0;
      else
         irq_lvl_q <= irq_lvl_d;
   end

   assign ad_out = ad_out_q;
   assign ad_oe = ad_oe_q;
   assign irq_out_n = irq_lvl_q;
   assign irq_out_n_oe = irq_oe_q;
   assign cfg = cfg_q;

endmodule : mhp_port

// *** testbench/mhp_port_chk.sv ***
`timescale 1ns/1ns
module mhp_port_chk (
   input wire logic clk_sys, // clock
   input wire logic reset_n, // power-up reset
   input wire logic cs_n, // chip select
   input wire logic ale, // address strobe
   input wire logic rd_n, // read or data strobe
   input wire logic wr_n, // write strobe or direction
   input wire logic bus_style_select, // style pin
   input wire logic dev_reset_n, // device reset pin
   input wire logic [7:0] ad_in, // bus input side
   input wire logic [7:0] ad_out, // bus output side
   input wire logic ad_oe, // bus drive enable
   input wire logic [7:0] irq_event, // request pulses
   input wire logic irq_out_n, // interrupt level
   input wire logic irq_out_n_oe, // interrupt pull enable
   input wire mhp_pkg::mhp_cfg_t cfg // config bits
);
   // ****************************************
   // port checks
   // ****************************************
   logic rd_cond;
   logic [11:0] hist_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // read condition at the pins; a style 1 write must never drive
   assign rd_cond = !cs_n && !rd_n && (!bus_style_select || wr_n);
   // history, since every pin passes a synchroniser first
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n) hist_q <= 12'h000;
      else hist_q <= {hist_q[10:4], !cs_n || !dev_reset_n, hist_q[2:0], rd_cond};
   end
   AST_OE_ONLY_READ: assert property (ad_oe |-> rd_cond || (|hist_q[3:0]))
      else $error("bus driven outside a read");
   AST_OE_RISE: assert property (rd_cond [*5] |-> ad_oe)
      else $error("read not answered");
   AST_CS_RELEASE: assert property (cs_n [*5] |-> !ad_oe)
      else $error("bus kept after chip select rose");
   // an event reaches ad_out two cycles later and a device reset fall only after the pin stages, so look back
   AST_OUT_STABLE: assert property (ad_oe && $past(ad_oe) && !cs_n && irq_event == 8'h00
      && $past(irq_event) == 8'h00 && $past(irq_event, 2) == 8'h00
      && ($past(dev_reset_n, 4) || !$past(dev_reset_n, 5))
      |-> $stable(ad_out)) else $error("read data moved");
   AST_IRQ_HOLD: assert property ($fell(irq_out_n_oe) |-> |hist_q[11:4])
      else $error("interrupt dropped without a clear");
   AST_DEV_ERR: assert property (!dev_reset_n [*6] |-> !irq_out_n_oe
      && {cfg.tx_err_en, cfg.clk_rec_err_en, cfg.rx_err_en} == 3'h0) else $error("err bits");
   AST_DEV_AUX: assert property (!dev_reset_n [*6] |-> cfg.tx_aux == 3'h0 && !cfg.rx_aux)
      else $error("aux enables survived reset");
   AST_DEV_CMD: assert property (!dev_reset_n [*6] |-> cfg.command[7:6] == 2'h0)
      else $error("added command bits survived reset");
   AST_CFG_QUIET: assert property ((cs_n && dev_reset_n) [*8] |-> $stable(cfg))
      else $error("config changed with no access");
   CVR_READ_STYLE1: cover property (ad_oe && bus_style_select);
   CVR_IRQ_CLEAR: cover property ($fell(irq_out_n_oe));
   CVR_DEV_RESET: cover property (!dev_reset_n [*6]);
endmodule : mhp_port_chk

bind mhp_port mhp_port_chk mhp_port_chk_inst (.clk_sys(clk_sys), .reset_n(reset_n),
   .cs_n(cs_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .bus_style_select(bus_style_select),
   .dev_reset_n(dev_reset_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
   .irq_event(irq_event), .irq_out_n(irq_out_n), .irq_out_n_oe(irq_out_n_oe), .cfg(cfg));

// *** testbench/mhp_host.sv ***
`timescale 1ns/1ns
module mhp_host (
   input wire logic clk_sys, // clock
   input wire logic style, // bus style in use
   input wire logic [7:0] ad_bus, // resolved bus level
   output logic cs_n, // chip select
   output logic ale, // address strobe
   output logic rd_n, // read or data strobe
   output logic wr_n, // write strobe or direction
   output logic [7:0] pad // host side of the bus
);
   logic drive;
   logic [7:0] val = 8'h00;
   logic [7:0] flt_q = 8'h3C;
   initial {cs_n, ale, rd_n, wr_n, drive} = 5'h16;
   // a released bus must not look like a held value
   always @(posedge clk_sys) flt_q <= ~flt_q;
   assign pad = drive ? val : flt_q;
   // one whole cycle; sel low strobes without chip select
   task automatic xfer(input logic sel, input logic wr, input logic [7:0] a, d,
      output logic [7:0] q);
      @(posedge clk_sys);
      ale <= 1'b1;
      drive <= 1'b1;
      val <= a;
      repeat (4) @(posedge clk_sys);
      ale <= 1'b0;
      repeat (2) @(posedge clk_sys);
      drive <= wr; // floats for a read
      val <= d;
      repeat (2) @(posedge clk_sys);
      cs_n <= !sel;
      rd_n <= wr && !style;
      wr_n <= !wr;
      repeat (6) @(posedge clk_sys);
      q = ad_bus;
      {cs_n, rd_n, wr_n, drive} <= 4'hE;
      repeat (5) @(posedge clk_sys);
   endtask : xfer
endmodule : mhp_host

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
   logic clk_sys;
   logic reset_n = 1'b0;
   logic style = 1'b0;
   logic dev_reset_n = 1'b1;
   logic [7:0] irq_event = 8'h00;
   logic cs_n, ale, rd_n, wr_n, ad_oe, irq_out_n, irq_out_n_oe, irq_pin;
   logic [7:0] pad, ad_out, ad_bus, q;
   mhp_pkg::mhp_cfg_t cfg;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   // ****************************************
   // bench
   // ****************************************
   // device drive wins the bus; the interrupt line has a pull-up
   assign ad_bus = ad_oe ? ad_out : pad;
   assign irq_pin = irq_out_n_oe ? irq_out_n : 1'b1;
   mhp_port mhp_port_inst (.clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .ale(ale),
      .rd_n(rd_n), .wr_n(wr_n), .bus_style_select(style), .dev_reset_n(dev_reset_n),
      .ad_in(ad_bus), .ad_out(ad_out), .ad_oe(ad_oe), .irq_event(irq_event),
      .irq_out_n(irq_out_n), .irq_out_n_oe(irq_out_n_oe), .cfg(cfg));
   mhp_host mhp_host_inst (.clk_sys(clk_sys), .style(style), .ad_bus(ad_bus),
      .cs_n(cs_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .pad(pad));
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : check
   task wr(input logic [7:0] a, input logic [7:0] d);
      mhp_host_inst.xfer(1'b1, 1'b1, a, d, q);
   endtask : wr
   task rd(input logic [7:0] a);
      mhp_host_inst.xfer(1'b1, 1'b0, a, 8'h00, q);
   endtask : rd
   task pulse(input logic [7:0] e);
      @(posedge clk_sys);
      irq_event <= e;
      @(posedge clk_sys);
      irq_event <= 8'h00;
      repeat (3) @(posedge clk_sys);
   endtask : pulse
   task test_power_up;
      rd(mhp_pkg::REG_IRQ_MASK);
      check(q, mhp_pkg::MASK_RESET);
      rd(mhp_pkg::REG_IRQ_REQUEST);
      check(q, 8'h00);
   endtask : test_power_up
   // data differs per style so a dead style cannot pass
   task test_access(input logic s);
      style <= s;
      wr(mhp_pkg::REG_ERR_ENABLE, 8'hA5 ^ {8{s}});
      wr(8'hFF, 8'h81 ^ {8{s}});
      wr(mhp_pkg::REG_IRQ_REQUEST, 8'h77);
      wr(mhp_pkg::REG_COMMAND, 8'h3C ^ {8{s}});
      mhp_host_inst.xfer(1'b0, 1'b1, mhp_pkg::REG_ERR_ENABLE, 8'h0F, q);
      rd(mhp_pkg::REG_ERR_ENABLE);
      check(q, 8'hA5 ^ {8{s}});
      rd(8'hFF);
      check(q, 8'h81 ^ {8{s}});
      rd(mhp_pkg::REG_IRQ_REQUEST);
      check(q, 8'h00);
      check(cfg.command, 8'h3C ^ {8{s}});
      check({5'h00, cfg.rx_err_en, cfg.clk_rec_err_en, cfg.tx_err_en}, 8'h05 ^ {5'h00, {3{s}}});
   endtask : test_access
   task test_irq;
      wr(mhp_pkg::REG_IRQ_MASK, 8'hFE);
      pulse(8'h02);
      check({7'h00, irq_pin}, 8'h01);
      pulse(8'h01);
      check({7'h00, irq_pin}, 8'h00);
      rd(mhp_pkg::REG_IRQ_REQUEST);
      check(q, 8'h03);
      wr(mhp_pkg::REG_IRQ_CLEAR, 8'hFD);
      check({7'h00, irq_pin}, 8'h00);
      wr(mhp_pkg::REG_IRQ_CLEAR, 8'hFE);
      check({7'h00, irq_pin}, 8'h01);
   endtask : test_irq
   task test_dev_reset;
      wr(mhp_pkg::REG_ERR_ENABLE, 8'hA7);
      wr(mhp_pkg::REG_TX_AUX, 8'h0F);
      wr(mhp_pkg::REG_COMMAND, 8'hFF);
      wr(mhp_pkg::REG_IRQ_MASK, 8'h00);
      check({4'h0, cfg.rx_aux, cfg.tx_aux}, 8'h0F);
      check({5'h00, cfg.rx_err_en, cfg.clk_rec_err_en, cfg.tx_err_en}, 8'h07);
      // a pending unmasked request so the reset has an active line to silence
      pulse(8'h04);
      check({7'h00, irq_pin}, 8'h00);
      dev_reset_n <= 1'b0;
      wr(8'h10, 8'h99);
      check({7'h00, irq_pin}, 8'h01);
      check({5'h00, cfg.rx_err_en, cfg.clk_rec_err_en, cfg.tx_err_en}, 8'h00);
      rd(8'h10);
      check(q, 8'h99);
      rd(mhp_pkg::REG_IRQ_REQUEST);
      check(q, 8'h04);
      rd(mhp_pkg::REG_IRQ_MASK);
      check(q, 8'hFF);
      rd(mhp_pkg::REG_ERR_ENABLE);
      check(q, 8'hA0);
      rd(mhp_pkg::REG_TX_AUX);
      check(q, 8'h08);
      rd(mhp_pkg::REG_COMMAND);
      check(q, 8'h3F);
      check({4'h0, cfg.rx_aux, cfg.tx_aux}, 8'h00);
      dev_reset_n <= 1'b1;
   endtask : test_dev_reset
   task finish_test;
      $display("checked %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   initial
   begin
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      test_power_up();
      test_access(1'b0);
      test_access(1'b1);
      test_irq();
      test_dev_reset();
      finish_test();
   end
   // a hung handshake ends the run as a failure
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         mismatches++;
         finish_test();
      end
   end
endmodule : testbench
